// ### design/mce_signal.sv
// machine check error line driver and observer
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module mce_signal (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // configuration
   input  wire mce_pkg::mce_cfg_s cfg,
   // error events (unrecoverable, non-protocol), one-cycle pulses
   input  wire mce_pkg::mce_evt_s evt,
   // shared open-drain line
   input  wire logic             machine_check_error_n_in,
   output logic                  machine_check_error_n_out,
   output logic                  machine_check_error_n_oe,
   // internal error pin
   output logic                  internal_error_out_n,
   // status
   input  wire logic             foreign_clear,
   output logic                  foreign_seen,
   output logic                  driving
);
   import mce_pkg::*;

   localparam int unsigned HOLD = `MCE_ASSERT_CYCLES;
   localparam int unsigned CW   = $clog2(HOLD + 1);

   //////////////////////////////////////////////////////////////////////////
   // cause decode
   wire logic cause_int  = cfg.enable & cfg.internal_err_en & evt.internal_err;
   wire logic cause_init = cfg.enable & cfg.initiator_err_en & evt.initiator_err;
   wire logic cause_obs  = evt.observed_err;
   wire logic fire       = cause_int | cause_init | cause_obs;

   mce_state_e    state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic          internal_error_out_n_q;
   logic          foreign_q;
   logic          line_sync;

   //////////////////////////////////////////////////////////////////////////
   // input synchroniser for the shared line
   mce_sync u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .din      (machine_check_error_n_in),
      .dout     (line_sync)
   );

   // next-state logic: drive for HOLD cycles, retrigger on new causes
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         MCE_IDLE: begin
            if (fire) begin
               state_d = MCE_DRIVE;
               cnt_d   = CW'(HOLD - 1);
            end
         end
         MCE_DRIVE: begin
            if (fire) begin
               cnt_d = CW'(HOLD - 1);
            end else if (cnt_q == '0) begin
               state_d = MCE_IDLE;
            end else begin
               cnt_d = cnt_q - CW'(1);
            end
         end
      endcase
   end

   // state registers; async reset releases the line at once
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= MCE_IDLE;
         cnt_q   <= '0;
         internal_error_out_n_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         internal_error_out_n_q  <= internal_error_out_n_q | evt.internal_err;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // own drive delayed by the synchroniser depth
   // masks the read-back of our own pulse after release
   logic drv_d1_q;
   logic drv_d2_q;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         drv_d1_q <= 1'b0;
         drv_d2_q <= 1'b0;
      end else begin
         drv_d1_q <= driving;
         drv_d2_q <= drv_d1_q;
      end
   end
   wire logic echo_blind = driving | drv_d1_q | drv_d2_q;

   // foreign assertion flag, set wins over clear
   wire logic foreign_evt = ~line_sync & ~echo_blind;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         foreign_q <= 1'b0;
      end else if (foreign_evt) begin
         foreign_q <= 1'b1;
      end else if (foreign_clear) begin
         foreign_q <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // open-drain outputs
   assign driving                   = (state_q == MCE_DRIVE);
   assign machine_check_error_n_out = 1'b0;
   assign machine_check_error_n_oe  = driving;
   assign internal_error_out_n      = ~internal_error_out_n_q;
   assign foreign_seen              = foreign_q;

   //////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_int_cause;
      cfg.enable && cfg.internal_err_en && evt.internal_err;
   endsequence

   sequence s_drive_and_internal_error_out_n;
      machine_check_error_n_oe && !internal_error_out_n;
   endsequence

   // full drive time after the last cause
   sequence s_full_hold;
      machine_check_error_n_oe [*4];
   endsequence

   // no own drive in the cycles the synchroniser looks back over
   sequence s_quiet_before;
      !$past(driving, 1) && !$past(driving, 2) && !$past(driving, 3);
   endsequence

   AST_INT_DRIVES: assert property (@(posedge core_clk) disable iff (rst)
      s_int_cause |=> s_drive_and_internal_error_out_n) else $error("internal error did not drive line");

   AST_INIT_DRIVES: assert property (@(posedge core_clk) disable iff (rst)
      cfg.enable && cfg.initiator_err_en && evt.initiator_err |=> machine_check_error_n_oe)
      else $error("initiator error did not drive line");

   AST_OBS_DRIVES: assert property (@(posedge core_clk) disable iff (rst)
      evt.observed_err |=> machine_check_error_n_oe) else $error("observed error did not drive line");

   AST_DISABLED_QUIET: assert property (@(posedge core_clk) disable iff (rst)
      !machine_check_error_n_oe && !cfg.enable && !evt.observed_err |=> !machine_check_error_n_oe)
      else $error("line driven while disabled");

   AST_NO_CAUSE: assert property (@(posedge core_clk) disable iff (rst)
      $rose(machine_check_error_n_oe) |-> $past(fire)) else $error("line driven without cause");

   AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (rst)
      machine_check_error_n_oe |-> machine_check_error_n_out == 1'b0) else $error("line driven high");

   AST_HOLD_LEN: assert property (@(posedge core_clk) disable iff (rst)
      $rose(machine_check_error_n_oe) && !fire |-> s_full_hold)
      else $error("drive pulse too short");

   AST_RESET_RELEASE: assert property (@(posedge core_clk)
      rst |-> !machine_check_error_n_oe) else $error("line held through reset");

   AST_FOREIGN_FLAG: assert property (@(posedge core_clk) disable iff (rst)
      foreign_evt |=> foreign_seen) else $error("foreign assertion not recorded");

   //////////////////////////////////////////////////////////////////////////
   // hold, sticky, echo and reset behaviour

   // a new cause while driving restarts the full hold
   AST_RETRIGGER: assert property (@(posedge core_clk) disable iff (rst)
      machine_check_error_n_oe && fire |=> s_full_hold)
      else $error("retrigger did not restart hold");

   // the line is let go once the hold runs out
   AST_RELEASE_AFTER_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      driving && (cnt_q == '0) && !fire |=> !driving)
      else $error("line held past its hold time");

   // internal error pin stays low until reset
   AST_INTERNAL_ERROR_OUT_N_STICKY: assert property (@(posedge core_clk) disable iff (rst)
      !internal_error_out_n |=> !internal_error_out_n)
      else $error("internal error pin released early");

   // internal error pin falls only after an internal error
   AST_INTERNAL_ERROR_OUT_N_ON_CAUSE: assert property (@(posedge core_clk) disable iff (rst)
      $fell(internal_error_out_n) |-> $past(evt.internal_err))
      else $error("internal error pin without internal error");

   // our own pulse never shows up as a foreign one
   AST_NO_ECHO: assert property (@(posedge core_clk) disable iff (rst)
      $rose(foreign_seen) |-> s_quiet_before)
      else $error("own drive recorded as foreign");

   // foreign flag set only from a low line sample through two flops
   AST_SYNC_DEPTH: assert property (@(posedge core_clk) disable iff (rst)
      $rose(foreign_seen) |-> !$past(machine_check_error_n_in, 3))
      else $error("foreign flag without low line");

   // clear without a new event drops the flag
   AST_FOREIGN_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      foreign_clear && !foreign_evt |=> !foreign_seen)
      else $error("foreign flag not cleared");

   // flag stays set until cleared
   AST_FOREIGN_STICKY: assert property (@(posedge core_clk) disable iff (rst)
      foreign_seen && !foreign_clear |=> foreign_seen)
      else $error("foreign flag lost");

   // all outputs idle at the first edge after reset
   AST_RESET_IDLE: assert property (@(posedge core_clk)
      $fell(rst) |-> !machine_check_error_n_oe && internal_error_out_n && !foreign_seen)
      else $error("outputs not idle after reset");
endmodule : mce_signal

// ### design/mce_sync.sv
// two-stage synchroniser for a single bit
`timescale 1ns/1ps
module mce_sync (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // data
   input  wire logic din,
   output logic      dout
);
   logic meta_q;
   logic sync_q;

   // two flops, reset to the idle (high) line level
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule : mce_sync

// ### shared/mce_cfg.svh
// timing constants and configuration field positions for the machine check error block
`ifndef MCE_CFG_SVH
`define MCE_CFG_SVH
// bus clock period in picoseconds (200 MHz)
`define MCE_CLK_PERIOD_PS      5000
// release of bus outputs after reset is seen, in bus clocks
`define MCE_RESET_RELEASE_CLKS 2
// least drive time of the error line, in nanoseconds, and its cycle count
`define MCE_ASSERT_TIME_NS     20
`define MCE_ASSERT_CYCLES      ((`MCE_ASSERT_TIME_NS * 1000 + `MCE_CLK_PERIOD_PS - 1) / `MCE_CLK_PERIOD_PS)
// configuration bit positions
`define MCE_CFG_ENABLE_BIT     0
`define MCE_CFG_INTERR_BIT     1
`define MCE_CFG_INITERR_BIT    2
`define MCE_CFG_WIDTH          3
`endif

// ### shared/mce_pkg.sv
// types for the machine check error block
`include "mce_cfg.svh"
package mce_pkg;
   // configuration straps
   typedef struct packed {
      logic initiator_err_en;
      logic internal_err_en;
      logic enable;
   } mce_cfg_s;
   // error event inputs from the core
   typedef struct packed {
      logic internal_err;
      logic initiator_err;
      logic observed_err;
   } mce_evt_s;
   // line driver states
   typedef enum logic [1:0] {
      MCE_IDLE,
      MCE_DRIVE
   } mce_state_e;
endpackage : mce_pkg

// ### test/machine_check_error_signalling_tb_top.sv
// self-checking bench of the error line block
`timescale 1ns/1ps
module machine_check_error_signalling_tb_top;
   import mce_pkg::*;
   logic core_clk = 0, rst = 0, fclr = 0, preq = 0, internal_error_out_n_seen = 0;
   logic [3:0] pdly = 4'h0, phold = 4'h0;
   mce_cfg_s cfg = '0;
   mce_evt_s evt = '0;
   logic oe, out, internal_error_out_n_n, fseen, drv, peer_oe, line;
   logic [31:0] seed = 32'h0000d82b;
   int num_errors = 0, num_checks = 0;
   // wired line with pull-up
   assign line = !(oe && !out) && !peer_oe;
   always #2.5 core_clk = ~core_clk;
   mce_signal dut (.core_clk(core_clk), .rst(rst), .cfg(cfg), .evt(evt), .machine_check_error_n_in(line),
      .machine_check_error_n_out(out), .machine_check_error_n_oe(oe), .internal_error_out_n(internal_error_out_n_n),
      .foreign_clear(fclr), .foreign_seen(fseen), .driving(drv));
   mce_peer peer (.core_clk(core_clk), .rst(rst), .req(preq), .dly(pdly), .hld(phold), .pull_oe(peer_oe));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic exp_drv(input mce_cfg_s c, input mce_evt_s e);
      return e.observed_err | (c.enable & ((c.internal_err_en & e.internal_err) |
                                           (c.initiator_err_en & e.initiator_err)));
   endfunction : exp_drv
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   task automatic chk(input logic got, input logic exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic finish_test;
      if (num_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test
   // one cause under one setting, then the hold and release
   task automatic fire(input mce_cfg_s c, input mce_evt_s e);
      logic x;
      x = exp_drv(c, e);
      cfg = c;
      step(1);
      evt = e;
      internal_error_out_n_seen |= e.internal_err;
      step(1);
      evt = '0;
      chk(oe, x, "drive start");
      chk(drv, x, "driving flag");
      chk(internal_error_out_n_n, !internal_error_out_n_seen, "internal error pin");
      chk(out, 1'b0, "open drain level");
      step(3);
      chk(oe, x, "drive hold");
      step(1);
      chk(oe, 1'b0, "drive end");
      step(3);
      chk(fseen, 1'b0, "echo of own drive");
   endtask : fire
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
   initial begin
      #1;
      rst = 1;
      step(6);
      rst = 0;
      chk(oe, 1'b0, "idle after reset");
      for (int i = 0; i < 64; i++) fire(mce_cfg_s'(i[5:3]), mce_evt_s'(i[2:0]));
      repeat (40) begin
         seed = xs(seed);
         fire(mce_cfg_s'(seed[2:0]), mce_evt_s'(seed[5:3]));
      end
      // retrigger three cycles after the first cause
      evt = mce_evt_s'(3'h1);
      step(1);
      evt = '0;
      step(2);
      evt = mce_evt_s'(3'h1);
      step(1);
      evt = '0;
      step(1);
      chk(oe, 1'b1, "retrigger extends");
      step(3);
      chk(oe, 1'b0, "retrigger end");
      // foreign pulls, prompt and slow
      repeat (3) begin
         seed = xs(seed);
         pdly = seed[3:0];
         phold = seed[7:4] | 4'h1;
         preq = 1;
         step(1);
         preq = 0;
         step(int'(pdly) + int'(phold) + 5);
         chk(fseen, 1'b1, "foreign seen");
         chk(oe, 1'b0, "no echo of foreign");
         fclr = 1;
         step(1);
         fclr = 0;
         chk(fseen, 1'b0, "foreign cleared");
      end
      // reset in mid-drive
      cfg = mce_cfg_s'(3'h7);
      evt = mce_evt_s'(3'h4);
      step(1);
      evt = '0;
      rst = 1;
      internal_error_out_n_seen = 0;
      step(2);
      chk(oe, 1'b0, "release on reset");
      chk(internal_error_out_n_n, 1'b1, "internal pin on reset");
      rst = 0;
      step(2);
      chk(oe, 1'b0, "idle after second reset");
      chk(fseen, 1'b0, "flag clear after second reset");
      fire(mce_cfg_s'(3'h7), mce_evt_s'(3'h4));
      finish_test();
   end
endmodule : machine_check_error_signalling_tb_top

// ### test/mce_peer.sv
// partner bus agent pulling the shared error line
`timescale 1ns/1ps
module mce_peer (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // pull request: wait dly cycles, pull for hld cycles
   input  wire logic       req,
   input  wire logic [3:0] dly,
   input  wire logic [3:0] hld,
   // open-drain pull enable
   output logic            pull_oe
);
   logic [3:0] wait_q;
   logic [3:0] left_q;
   // open drain: only pulls low, never drives high
   assign pull_oe = (wait_q == 4'h0) && (left_q != 4'h0);
   // schedule of one pull, dropped at once on reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_q <= 4'h0;
         left_q <= 4'h0;
      end else if (req) begin
         wait_q <= dly;
         left_q <= hld;
      end else if (wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end else if (left_q != 4'h0) begin
         left_q <= left_q - 4'h1;
      end
   end
endmodule : mce_peer
